//--- rtl/pps_device.sv
/*
  Pin output routing device: per-pin source select, input select,
  lock register with key sequence, pad level select and port read.
  Assumes the link and the peripheral signals run on clk; pin levels
  arrive from outside and are synchronised here. rst_n is the power-on
  or brown-out reset; softReset is any other device reset, one cycle.
*/
`timescale 1ns/100ps

// Summary of operation
// - each pin has its own source select
// - direction bit enables driver for ordinary sources
// - self-driving peripheral overrides the direction bit
// - codes 0-8: latch, logic cells, waveforms
// - codes 9-0x13: capture, pwm, serial outputs
// - codes 0x14-0x1c: comparator to guards; reserved
// - software routes bidirectional input and output identically
// - pad levels follow input level select bits
// - unlocked selections accept plain writes
// - locked selections refuse all writes
// - setting lock needs 0x55, 0xaa first
// - clearing lock needs the same key
// - software masks interrupts around key sequence
// - one-way option: set once, no clear
// - without option lock toggles freely with key
// - sleep leaves all selections untouched
// - power-on reset restores input defaults, clears outputs
// - other resets keep all selections
// - every reset clears the lock
// - input select: port bits 5:3, pin 2:0
// - port read returns real pin level
module pps_device (
  input wire logic clk,
  input wire logic rst_n,
  pps_link_if.device link,
  input wire logic softReset,
  input wire logic lockOnceCfg,
  input wire logic [pps_pkg::PIN_COUNT-1:0] portLatch,
  input wire logic [pps_pkg::PIN_COUNT-1:0] pinDirection,
  input wire logic [pps_pkg::PIN_COUNT-1:0] pinIn,
  input wire logic [pps_pkg::SRC_COUNT-1:0] srcOut,
  input wire logic [pps_pkg::SRC_COUNT-1:0] srcOwnsDrv,
  input wire logic [pps_pkg::SRC_COUNT-1:0] srcOe_n,
  output logic [pps_pkg::PIN_COUNT-1:0] pinOut,
  output logic [pps_pkg::PIN_COUNT-1:0] pinOe_n,
  output logic [pps_pkg::PIN_COUNT-1:0] pinSchmitt,
  output logic [pps_pkg::IN_SEL_COUNT-1:0] periphIn,
  output logic routingLocked
);

  // whole state of the device in one record
  typedef struct packed {
    logic [pps_pkg::PIN_COUNT-1:0][4:0] outSel; // pin_output_source_select
    logic [pps_pkg::IN_SEL_COUNT-1:0][5:0] inSel; // peripheral_input_pin_select
    logic [pps_pkg::PIN_COUNT-1:0] inLevel; // input_level_select, both ports
    logic locked; // routing_locked_flag
    logic lockUsed; // lock was set since the last reset
    pps_pkg::key_state_t keyState; // progress through the key
    logic [pps_pkg::PIN_COUNT-1:0] pinMeta; // first synchroniser stage
    logic [pps_pkg::PIN_COUNT-1:0] pinSync; // second synchroniser stage
    logic [pps_pkg::PIN_COUNT-1:0] pinOut; // registered pin data
    logic [pps_pkg::PIN_COUNT-1:0] pinOe_n; // registered pin enable, low drives
    logic [pps_pkg::IN_SEL_COUNT-1:0] periphIn; // routed peripheral inputs
    logic rspValid; // answer pulse
    logic [7:0] rspData; // answer data
  } dev_state_t;

  dev_state_t state_ff; // registered state
  dev_state_t nxt_state; // next state

  logic [pps_pkg::PIN_COUNT-1:0] muxOut; // per-pin routed data
  logic [pps_pkg::PIN_COUNT-1:0] muxOe_n; // per-pin routed enable
  logic [pps_pkg::IN_SEL_COUNT-1:0] muxIn; // per-input routed level

  // per-pin output routing
  genvar gi;
  generate
    for (gi = 0; gi < pps_pkg::PIN_COUNT; gi++) begin : g_pin
      logic [4:0] code; // this pin's source code
      logic srcBit; // selected peripheral level
      logic owns; // selected peripheral drives the pad itself
      logic srcEn_n; // that peripheral's own enable
      assign code = state_ff.outSel[gi];
      // source decode: out-of-range codes give zero
      assign srcBit = (code < 5'(pps_pkg::SRC_COUNT)) ? srcOut[code] : 1'b0;
      assign owns = (code < 5'(pps_pkg::SRC_COUNT)) ? srcOwnsDrv[code] : 1'b0;
      assign srcEn_n = (code < 5'(pps_pkg::SRC_COUNT)) ? srcOe_n[code] : 1'b1;
      assign muxOut[gi] = (code == pps_pkg::SRC_PORT_LATCH) ? portLatch[gi] : srcBit;
      // direction bit otherwise, high means input
      assign muxOe_n[gi] = (code != pps_pkg::SRC_PORT_LATCH && owns) ? srcEn_n : pinDirection[gi];
    end
  endgenerate

  // per-input selection of a synchronised pin level
  generate
    for (gi = 0; gi < pps_pkg::IN_SEL_COUNT; gi++) begin : g_in
      logic [2:0] port; // selected port, 0 is A
      logic [2:0] pin; // selected pin in port
      assign port = state_ff.inSel[gi][pps_pkg::IN_PORT_LSB +: 3];
      assign pin = state_ff.inSel[gi][pps_pkg::IN_PIN_MSB:0];
      // only ports A and B exist here; other ports read low
      assign muxIn[gi] = (port < 3'd2) ? state_ff.pinSync[{port[0], pin}] : 1'b0;
    end
  endgenerate

  // next-state logic: link access, key sequence, resets
  always_comb begin
    logic wrSel; // write hits a selection register
    logic [7:0] a; // request address
    logic [7:0] d; // request data
    wrSel = 1'b0;
    a = link.reqAddr;
    d = link.reqData;
    nxt_state = state_ff;
    // the first stage only feeds the second
    nxt_state.pinMeta = pinIn;
    nxt_state.pinSync = state_ff.pinMeta;
    nxt_state.pinOut = muxOut;
    nxt_state.pinOe_n = muxOe_n;
    nxt_state.periphIn = muxIn;
    nxt_state.rspValid = link.reqValid;
    nxt_state.rspData = 8'h00;
    // no sleep term reaches any selection
    if (link.reqValid) begin
      // any access other than the next key step aborts
      nxt_state.keyState = pps_pkg::KEY_IDLE;
      if (link.reqWrite) begin
        wrSel = (a < pps_pkg::ADDR_IN_SEL_BASE + 8'(pps_pkg::IN_SEL_COUNT));
        if (a == pps_pkg::ADDR_LOCK) begin
          case (state_ff.keyState)
            pps_pkg::KEY_IDLE: begin
              if (d == pps_pkg::KEY_FIRST) begin
                nxt_state.keyState = pps_pkg::KEY_GOT_FIRST;
              end
            end
            pps_pkg::KEY_GOT_FIRST: begin
              if (d == pps_pkg::KEY_SECOND) begin
                nxt_state.keyState = pps_pkg::KEY_ARMED;
              end
            end
            pps_pkg::KEY_ARMED: begin
              // one-way option allows one set per reset
              if (d[pps_pkg::LOCKED_BIT] && !(lockOnceCfg && state_ff.lockUsed)) begin
                nxt_state.locked = 1'b1;
                nxt_state.lockUsed = 1'b1;
              end
              // repeated clears allowed without the option
              if (!d[pps_pkg::LOCKED_BIT] && !lockOnceCfg) begin
                nxt_state.locked = 1'b0;
              end
            end
            default: begin
              nxt_state.keyState = pps_pkg::KEY_IDLE;
            end
          endcase
        end else if (a == pps_pkg::ADDR_INPUT_LEVEL_SELECT_A) begin
          // pad level select for port A
          nxt_state.inLevel[7:0] = d;
        end else if (a == pps_pkg::ADDR_INPUT_LEVEL_SELECT_B) begin
          nxt_state.inLevel[15:8] = d;
        end else if (wrSel && !state_ff.locked) begin
          if (a < pps_pkg::ADDR_IN_SEL_BASE) begin
            nxt_state.outSel[a[3:0]] = d[4:0];
          end else begin
            nxt_state.inSel[a[1:0]] = d[5:0];
          end
        end
      end else begin
        // read answers
        if (a < pps_pkg::ADDR_IN_SEL_BASE) begin
          nxt_state.rspData = {3'b000, state_ff.outSel[a[3:0]]};
        end else if (a < pps_pkg::ADDR_IN_SEL_BASE + 8'(pps_pkg::IN_SEL_COUNT)) begin
          nxt_state.rspData = {2'b00, state_ff.inSel[a[1:0]]};
        end else if (a == pps_pkg::ADDR_LOCK) begin
          nxt_state.rspData = {7'h00, state_ff.locked};
        end else if (a == pps_pkg::ADDR_INPUT_LEVEL_SELECT_A) begin
          nxt_state.rspData = state_ff.inLevel[7:0];
        end else if (a == pps_pkg::ADDR_INPUT_LEVEL_SELECT_B) begin
          nxt_state.rspData = state_ff.inLevel[15:8];
        end else if (a == pps_pkg::ADDR_PORT_A) begin
          // real pin level, not the routed view
          nxt_state.rspData = state_ff.pinSync[7:0];
        end else if (a == pps_pkg::ADDR_PORT_B) begin
          nxt_state.rspData = state_ff.pinSync[15:8];
        end else begin
          nxt_state.rspData = 8'h00;
        end
      end
    end
    if (softReset) begin
      nxt_state.locked = 1'b0;
      nxt_state.lockUsed = 1'b0;
      nxt_state.keyState = pps_pkg::KEY_IDLE;
    end
  end

  // state register; power-on reset loads constants only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // output selects cleared, input selects to default
      state_ff.outSel <= {pps_pkg::PIN_COUNT{pps_pkg::OUT_SEL_RESET}};
      state_ff.inSel <= pps_pkg::IN_SEL_RESET;
      state_ff.inLevel <= {2{pps_pkg::INPUT_LEVEL_SELECT_RESET}};
      state_ff.locked <= 1'b0;
      state_ff.lockUsed <= 1'b0;
      state_ff.keyState <= pps_pkg::KEY_IDLE;
      state_ff.pinMeta <= '0;
      state_ff.pinSync <= '0;
      state_ff.pinOut <= '0;
      // all pads released during reset
      state_ff.pinOe_n <= '1;
      state_ff.periphIn <= '0;
      state_ff.rspValid <= 1'b0;
      state_ff.rspData <= 8'h00;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign pinOut = state_ff.pinOut;
  assign pinOe_n = state_ff.pinOe_n;
  // schmitt when bit set, ttl otherwise
  assign pinSchmitt = state_ff.inLevel;
  assign periphIn = state_ff.periphIn;
  assign routingLocked = state_ff.locked;
  assign link.rspValid = state_ff.rspValid;
  assign link.rspData = state_ff.rspData;
endmodule

//--- rtl/pps_pkg.sv
/*
  Shared constants for the pin output routing block with its lock.
  Assumes both ends are built on the same 40 MHz clock and reset.
*/
package pps_pkg;
  // pin count: two eight-bit ports, A and B
  localparam int PIN_COUNT = 16;
  // number of peripheral input selection registers
  localparam int IN_SEL_COUNT = 4;
  // number of output source codes, 0x00 through 0x1c
  localparam int SRC_COUNT = 29;

  // output source codes for pin_output_source_select
  typedef enum logic [4:0] {
    SRC_PORT_LATCH = 5'h00, SRC_LOGIC_CELL_1 = 5'h01, SRC_LOGIC_CELL_2 = 5'h02,
    SRC_LOGIC_CELL_3 = 5'h03, SRC_LOGIC_CELL_4 = 5'h04, SRC_WAVEFORM_A = 5'h05,
    SRC_WAVEFORM_B = 5'h06, SRC_WAVEFORM_C = 5'h07, SRC_WAVEFORM_D = 5'h08,
    SRC_CAPTURE_COMPARE_1 = 5'h09, SRC_CAPTURE_COMPARE_2 = 5'h0a,
    SRC_PULSE_WIDTH_3 = 5'h0b, SRC_PULSE_WIDTH_4 = 5'h0c, SRC_PULSE_WIDTH_5 = 5'h0d,
    SRC_SERIAL_TX_CLK_1 = 5'h0e, SRC_RESERVED_0F = 5'h0f, SRC_SERIAL_SYNC_DATA_1 = 5'h10,
    SRC_SERIAL_TX_CLK_2 = 5'h11, SRC_RESERVED_12 = 5'h12, SRC_SERIAL_SYNC_DATA_2 = 5'h13,
    SRC_COMPARATOR = 5'h14, SRC_SYNC_PORT_CLOCK_1 = 5'h15, SRC_SYNC_PORT_DATA_1 = 5'h16,
    SRC_SYNC_PORT_CLOCK_2 = 5'h17, SRC_SYNC_PORT_DATA_2 = 5'h18, SRC_TIMER_ZERO = 5'h19,
    SRC_NUMERIC_OSC = 5'h1a, SRC_CONVERTER_GUARD_A = 5'h1b, SRC_CONVERTER_GUARD_B = 5'h1c
  } src_code_t;

  // device register addresses on the link
  localparam logic [7:0] ADDR_OUT_SEL_BASE = 8'h00;
  localparam logic [7:0] ADDR_IN_SEL_BASE = 8'h10;
  localparam logic [7:0] ADDR_LOCK = 8'h20;
  localparam logic [7:0] ADDR_INPUT_LEVEL_SELECT_A = 8'h21;
  localparam logic [7:0] ADDR_INPUT_LEVEL_SELECT_B = 8'h22;
  localparam logic [7:0] ADDR_PORT_A = 8'h24;
  localparam logic [7:0] ADDR_PORT_B = 8'h25;

  // key values written to routing_lock_register
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // routing_locked_flag position in routing_lock_register
  localparam int LOCKED_BIT = 0;

  // peripheral_input_pin_select field positions
  localparam int IN_PORT_LSB = 3;
  localparam int IN_PIN_MSB = 2;

  // input select values after power-on: B0, A4, B5, A1
  localparam logic [IN_SEL_COUNT-1:0][5:0] IN_SEL_RESET = {6'h01, 6'h0d, 6'h04, 6'h08};
  localparam logic [4:0] OUT_SEL_RESET = 5'h00;
  localparam logic [7:0] INPUT_LEVEL_SELECT_RESET = 8'h00;

  // key sequence states, one-hot
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT_FIRST = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_t;

  // controller registers on APB (byte addresses)
  localparam logic [11:0] APB_CMD = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  // command word fields
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  // status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDATA_LSB = 8;
endpackage

//--- rtl/pps_link_if.sv
/*
  Register link between the routing controller and the routing device.
  Assumes both ends share one clock; no timing is carried here.
*/
`timescale 1ns/100ps
interface pps_link_if;
  logic reqValid; // one-cycle request pulse
  logic reqWrite; // 1 write, 0 read
  logic [7:0] reqAddr; // device register address
  logic [7:0] reqData; // write data
  logic rspValid; // one-cycle answer pulse
  logic [7:0] rspData; // read data, zero for writes

  modport device (
    input reqValid,
    input reqWrite,
    input reqAddr,
    input reqData,
    output rspValid,
    output rspData
  );

  modport host (
    output reqValid,
    output reqWrite,
    output reqAddr,
    output reqData,
    input rspValid,
    input rspData
  );
endinterface

//--- rtl/pps_host.sv
/*
  Routing controller: APB slave whose command register issues one
  register access on the link and whose status register reports it.
  Assumes APB and the link share clk; one access in flight at a time.
*/
`timescale 1ns/100ps
module pps_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pps_link_if.host link
);

  // whole state of the controller in one record
  typedef struct packed {
    logic ready; // access phase answer
    logic err; // unmapped address
    logic [31:0] rdata; // read word
    logic busy; // link access in flight
    logic [7:0] lastData; // last answer data
    logic reqValid; // link request pulse
    logic reqWrite; // link direction
    logic [7:0] reqAddr; // link address
    logic [7:0] reqData; // link write data
  } host_state_t;

  host_state_t state_ff; // registered state
  host_state_t nxt_state; // next state

  // apb decode and link sequencing
  always_comb begin
    logic setup; // setup cycle
    logic done; // completing access phase
    logic mapped; // address known
    setup = psel && !penable;
    done = psel && penable && state_ff.ready;
    mapped = (paddr == pps_pkg::APB_CMD) || (paddr == pps_pkg::APB_STATUS);
    nxt_state = state_ff;
    nxt_state.reqValid = 1'b0;
    // answer in the first access cycle, then drop
    nxt_state.ready = setup;
    nxt_state.err = setup && !mapped;
    nxt_state.rdata = 32'h0000_0000;
    if (setup && !pwrite && paddr == pps_pkg::APB_STATUS) begin
      nxt_state.rdata[pps_pkg::STAT_BUSY_BIT] = state_ff.busy || state_ff.reqValid;
      nxt_state.rdata[pps_pkg::STAT_RDATA_LSB +: 8] = state_ff.lastData;
    end
    // one access per command keeps the key writes in order
    if (done && pwrite && paddr == pps_pkg::APB_CMD && !state_ff.busy) begin
      nxt_state.busy = 1'b1;
      nxt_state.reqValid = 1'b1;
      nxt_state.reqWrite = pwdata[pps_pkg::CMD_WRITE_BIT];
      nxt_state.reqAddr = pwdata[pps_pkg::CMD_ADDR_LSB +: 8];
      nxt_state.reqData = pwdata[pps_pkg::CMD_DATA_LSB +: 8];
    end
    // answer from the device ends the access
    if (link.rspValid) begin
      nxt_state.busy = 1'b0;
      nxt_state.lastData = link.rspData;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign prdata = state_ff.rdata;
  assign pready = state_ff.ready;
  assign pslverr = state_ff.err;
  assign link.reqValid = state_ff.reqValid;
  assign link.reqWrite = state_ff.reqWrite;
  assign link.reqAddr = state_ff.reqAddr;
  assign link.reqData = state_ff.reqData;
endmodule

//--- sim/pps_chk.sv
/*
  Link checker for the routing controller and routing device.
  Assumes it sits beside the link interface, on the shared clock.
*/
`timescale 1ns/100ps
module pps_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqData,
  input wire logic rspValid,
  input wire logic [7:0] rspData
);
  // one link request with the answer it got
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] r;
  } req_rec_t;
  req_rec_t [3:0] hist_ff; // last four requests, newest at 0
  logic keyThenSet; // key pair then a lock write with bit0 set
  logic selAfterLockRd; // read sel after write of it, lock read before

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // record requests; the answer lands in the slot one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_ff <= '0;
    end else if (reqValid) begin
      hist_ff <= {hist_ff[2:0], reqWrite, reqAddr, reqData, 8'h00};
    end else if (rspValid) begin
      hist_ff[0].r <= rspData;
    end
  end

  // only back-to-back link writes form a key, so history is enough
  assign keyThenSet = hist_ff[3].w && hist_ff[3].a == pps_pkg::ADDR_LOCK
    && hist_ff[3].d == pps_pkg::KEY_FIRST && hist_ff[2].w
    && hist_ff[2].a == pps_pkg::ADDR_LOCK && hist_ff[2].d == pps_pkg::KEY_SECOND
    && hist_ff[1].w && hist_ff[1].a == pps_pkg::ADDR_LOCK && hist_ff[1].d[0];
  assign selAfterLockRd = !hist_ff[0].w && hist_ff[0].a < 8'h10 && hist_ff[1].w
    && hist_ff[1].a == hist_ff[0].a && !hist_ff[2].w && hist_ff[2].a == pps_pkg::ADDR_LOCK;

  property p_rsp_next;
    reqValid |=> rspValid;
  endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("request not answered");
  property p_rsp_cause;
    rspValid |-> $past(reqValid);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without request");
  property p_wr_zero;
    reqValid && reqWrite |=> rspData == 8'h00;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer not zero");
  property p_req_gap;
    reqValid |=> !reqValid [*2];
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("requests too close");
  property p_out_width;
    reqValid && !reqWrite && reqAddr < 8'h10 |=> rspData[7:5] == 3'b000;
  endproperty
  a_out_width: assert property (p_out_width) else $error("output code too wide");
  property p_in_width;
    reqValid && !reqWrite && reqAddr inside {[8'h10:8'h13]} |=> rspData[7:6] == 2'b00;
  endproperty
  a_in_width: assert property (p_in_width) else $error("input select too wide");
  property p_lock_set;
    rspValid && !hist_ff[0].w && hist_ff[0].a == pps_pkg::ADDR_LOCK && keyThenSet
      |-> rspData[0];
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set after key");
  property p_open_write;
    rspValid && selAfterLockRd && !hist_ff[2].r[0]
      |-> rspData == {3'b000, hist_ff[1].d[4:0]};
  endproperty
  a_open_write: assert property (p_open_write) else $error("unlocked write lost");
  property p_locked_write;
    rspValid && selAfterLockRd && hist_ff[2].r[0] && !hist_ff[3].w
      && hist_ff[3].a == hist_ff[0].a |-> rspData == hist_ff[3].r;
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write taken");
endmodule

//--- sim/tb.sv
/*
  Testbench: APB drives the controller, which reaches the device over
  the link; peripheral and pin levels come from here. Assumes one clock.
*/
`timescale 1ns/100ps
module tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, softReset;
  logic lockOnceCfg, routingLocked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] portLatch, pinDirection, pinIn, pinOut, pinOe_n, pinSchmitt;
  logic [28:0] srcOut, srcOwnsDrv, srcOe_n;
  logic [3:0] periphIn;
  int n_fail, n_checks;

  pps_link_if link();
  pps_host i_pps_host (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link(link));
  pps_device i_pps_device (.clk, .rst_n, .link(link), .softReset, .lockOnceCfg,
    .portLatch, .pinDirection, .pinIn, .srcOut, .srcOwnsDrv, .srcOe_n, .pinOut,
    .pinOe_n, .pinSchmitt, .periphIn, .routingLocked);
  pps_chk i_pps_chk (.clk(clk), .rst_n(rst_n), .reqValid(link.reqValid),
    .reqWrite(link.reqWrite), .reqAddr(link.reqAddr), .reqData(link.reqData),
    .rspValid(link.rspValid), .rspData(link.rspData));

  always #12.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // one device access: command, then poll status until idle
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    logic [31:0] s;
    logic e;
    apb(1'b1, pps_pkg::APB_CMD, {15'h0000, w, a, d}, s, e);
    s = 32'h1;
    while (s[pps_pkg::STAT_BUSY_BIT] !== 1'b0) apb(1'b0, pps_pkg::APB_STATUS, '0, s, e);
    r = s[15:8];
  endtask

  task automatic key(input logic [7:0] v);
    logic [7:0] r;
    // nothing may interleave, so the three writes go back to back
    dev(1'b1, pps_pkg::ADDR_LOCK, pps_pkg::KEY_FIRST, r);
    dev(1'b1, pps_pkg::ADDR_LOCK, pps_pkg::KEY_SECOND, r);
    dev(1'b1, pps_pkg::ADDR_LOCK, v, r);
  endtask

  // read a select, read the lock, write the select, read it again
  task automatic try_sel(input logic [7:0] a, input logic [7:0] d, input logic lk);
    logic [7:0] r0, r;
    dev(1'b0, a, 8'h00, r0);
    dev(1'b0, pps_pkg::ADDR_LOCK, 8'h00, r);
    chk(r[0], lk);
    dev(1'b1, a, d, r);
    dev(1'b0, a, 8'h00, r);
    chk(r, lk ? r0 : d);
  endtask

  task automatic t_por;
    logic [7:0] r;
    for (int i = 0; i < 16; i++) begin
      dev(1'b0, 8'(i), 8'h00, r);
      chk(r, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      dev(1'b0, 8'h10 + 8'(i), 8'h00, r);
      chk(r, {2'b00, pps_pkg::IN_SEL_RESET[i]});
    end
    chk(routingLocked, 1'b0);
  endtask

  // every mapped code drives pin 3; the inverse pattern proves exact selection
  task automatic t_routes;
    logic [7:0] r;
    pinDirection <= 16'hfff7;
    for (int c = 0; c < pps_pkg::SRC_COUNT; c++) begin
      if (c == 15 || c == 18) continue;
      dev(1'b1, 8'h03, 8'(c), r);
      srcOut <= 29'h1 << c;
      portLatch <= 16'h0008;
      repeat (2) @(posedge clk);
      chk(pinOut[3], 1'b1);
      srcOut <= ~(29'h1 << c);
      portLatch <= (c == 0) ? 16'h0000 : 16'hffff;
      repeat (2) @(posedge clk);
      chk(pinOut[3], 1'b0);
    end
  endtask

  task automatic t_dir;
    logic [7:0] r;
    dev(1'b1, 8'h05, 8'h01, r);
    pinDirection <= 16'hffdf;
    repeat (2) @(posedge clk);
    chk(pinOe_n[5], 1'b0);
    pinDirection <= 16'hffff;
    repeat (2) @(posedge clk);
    chk(pinOe_n[5], 1'b1);
    dev(1'b1, 8'h05, 8'h15, r);
    dev(1'b1, 8'h11, 8'h05, r);
    srcOwnsDrv <= 29'h1 << 21;
    srcOe_n <= ~(29'h1 << 21);
    pinIn <= 16'h0020;
    repeat (4) @(posedge clk);
    chk(pinOe_n[5], 1'b0);
    chk(periphIn[1], 1'b1);
    srcOe_n <= '1;
    repeat (2) @(posedge clk);
    chk(pinOe_n[5], 1'b1);
  endtask

  task automatic t_input;
    logic [7:0] r;
    logic [31:0] s;
    logic e;
    dev(1'b1, 8'h10, 8'h0a, r);
    pinIn <= 16'h0400;
    repeat (4) @(posedge clk);
    chk(periphIn[0], 1'b1);
    pinIn <= 16'h5a00;
    repeat (4) @(posedge clk);
    chk(periphIn[0], 1'b0);
    dev(1'b0, pps_pkg::ADDR_PORT_B, 8'h00, r);
    chk(r, 8'h5a);
    dev(1'b1, pps_pkg::ADDR_INPUT_LEVEL_SELECT_A, 8'h3c, r);
    dev(1'b0, pps_pkg::ADDR_INPUT_LEVEL_SELECT_A, 8'h00, r);
    chk(r, 8'h3c);
    chk(pinSchmitt[7:0], 8'h3c);
    apb(1'b0, 12'h008, '0, s, e);
    chk(e, 1'b1);
  endtask

  task automatic t_lock;
    logic [7:0] r;
    try_sel(8'h06, 8'h09, 1'b0);
    key(8'h01);
    chk(routingLocked, 1'b1);
    dev(1'b0, pps_pkg::ADDR_LOCK, 8'h00, r);
    chk(r, 8'h01);
    try_sel(8'h06, 8'h0b, 1'b1);
    try_sel(8'h12, 8'h22, 1'b1);
    for (int i = 0; i < 2; i++) begin
      key(8'h00);
      chk(routingLocked, 1'b0);
      key(8'h01);
      chk(routingLocked, 1'b1);
    end
    key(8'h00);
    // a read between the key writes must spoil the sequence
    dev(1'b1, pps_pkg::ADDR_LOCK, pps_pkg::KEY_FIRST, r);
    dev(1'b0, 8'h00, 8'h00, r);
    dev(1'b1, pps_pkg::ADDR_LOCK, pps_pkg::KEY_SECOND, r);
    dev(1'b1, pps_pkg::ADDR_LOCK, 8'h01, r);
    chk(routingLocked, 1'b0);
    // a wrong value between the key writes spoils it as well
    dev(1'b1, pps_pkg::ADDR_LOCK, pps_pkg::KEY_FIRST, r);
    dev(1'b1, pps_pkg::ADDR_LOCK, 8'h33, r);
    dev(1'b1, pps_pkg::ADDR_LOCK, pps_pkg::KEY_SECOND, r);
    dev(1'b1, pps_pkg::ADDR_LOCK, 8'h01, r);
    chk(routingLocked, 1'b0);
    key(8'h00);
    dev(1'b1, pps_pkg::ADDR_LOCK, 8'h01, r);
    chk(routingLocked, 1'b0);
  endtask

  task automatic t_once;
    logic [7:0] r;
    lockOnceCfg <= 1'b1;
    dev(1'b1, 8'h06, 8'h0c, r);
    key(8'h01);
    chk(routingLocked, 1'b1);
    key(8'h00);
    chk(routingLocked, 1'b1);
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    @(posedge clk);
    chk(routingLocked, 1'b0);
    dev(1'b0, 8'h06, 8'h00, r);
    chk(r, 8'h0c);
    key(8'h01);
    chk(routingLocked, 1'b1);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under this
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    {clk, rst_n, psel, penable, pwrite, softReset, lockOnceCfg} = '0;
    {paddr, pwdata, portLatch, pinIn, srcOut, srcOwnsDrv} = '0;
    pinDirection = '1;
    srcOe_n = '1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_por();
    t_routes();
    t_dir();
    t_input();
    t_lock();
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_por();
    t_once();
    test_done();
  end
endmodule
